/* File: pkg/fgr_pkg.sv */
// Purpose: Constants and carriers for the fast A20 / fast reset port block
// Assumes: 50 MHz block clock
// Notes: Host port numbers are used directly as register addresses
package fgr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] FAST_PORT_ADDR = 8'h92;
  localparam logic [7:0] CONFIG_ADDR = 8'hf0;
  localparam logic [7:0] FAST_PORT_RESET = 8'h24;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // Fixed read pattern of the reserved port bits
  localparam logic [7:0] FAST_PORT_FIXED_MASK = 8'hfc;
  localparam logic [7:0] FAST_PORT_FIXED_VAL = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int FAST_RESET_BIT = 0;
  localparam int FAST_A20_BIT = 1;
  localparam int PORT_EN_BIT = 2;
  localparam int KBD_LATCH_SEL_BIT = 3;
  localparam int MOUSE_LATCH_SEL_BIT = 4;
  localparam int RESET_POL_BIT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_DELAY_NS = 14000;
  localparam int RST_PULSE_NS = 6000;
  localparam int RST_DELAY_CYC = (RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fgr_req_t;

  typedef struct packed {
    logic kbc_reset;
    logic kbc_gate_port_bit;
    logic kbd_irq;
    logic mouse_irq;
  } fgr_kbc_t;

  typedef enum logic [1:0] {
    FGR_IDLE,
    FGR_DELAY,
    FGR_PULSE,
    FGR_DONE
  } fgr_state_t;

endpackage

/* File: design/fgr_fast_port.sv */
// Purpose: Fast A20 gate and fast CPU reset port with interrupt latch select
// Assumes: Host port accesses arrive as one-cycle strobes on ref_clk
// Notes: Controller signals come from other clock domains and are synchronised
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns

module fgr_fast_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire fgr_pkg::fgr_req_t req,
  output logic [7:0] rdata,
  input wire fgr_pkg::fgr_kbc_t kbc,
  output logic fast_reset_n,
  output logic fast_a20,
  output logic kbd_reset_out_n,
  output logic a20_mask_n,
  output logic kbd_irq_out,
  output logic mouse_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  fgr_pkg::fgr_kbc_t kbc_s1_r;
  fgr_pkg::fgr_kbc_t kbc_s2_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kbc_s1_r <= '0;
      kbc_s2_r <= '0;
    end else begin
      kbc_s1_r <= kbc;
      kbc_s2_r <= kbc_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic a20_r;
  logic a20_nxt;
  logic rst_bit_r;
  logic rst_bit_nxt;

  wire port_en = cfg_r[fgr_pkg::PORT_EN_BIT];
  wire hit_port = (req.addr == fgr_pkg::FAST_PORT_ADDR) && port_en;
  wire hit_cfg = (req.addr == fgr_pkg::CONFIG_ADDR);
  wire wr_port = req.wr && hit_port;
  wire wr_cfg = req.wr && hit_cfg;
  wire rd_port = req.rd && hit_port;
  wire rd_cfg = req.rd && hit_cfg;

  assign cfg_nxt = wr_cfg ? req.wdata : cfg_r;
  assign a20_nxt = wr_port ? req.wdata[fgr_pkg::FAST_A20_BIT] : a20_r;
  assign rst_bit_nxt = wr_port ? req.wdata[fgr_pkg::FAST_RESET_BIT] : rst_bit_r;

  // Port read value with fixed reserved bits
  wire [7:0] port_rd = (fgr_pkg::FAST_PORT_FIXED_VAL & fgr_pkg::FAST_PORT_FIXED_MASK)
                     | {6'h00, a20_r, rst_bit_r};
  wire [7:0] rdata_nxt = rd_port ? port_rd : (rd_cfg ? cfg_r : 8'h00);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= fgr_pkg::CONFIG_RESET;
      a20_r <= fgr_pkg::FAST_PORT_RESET[fgr_pkg::FAST_A20_BIT] & 1'b0;
      rst_bit_r <= 1'b0;
      rdata <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      a20_r <= a20_nxt;
      rst_bit_r <= rst_bit_nxt;
      rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast reset pulse sequencer
  fgr_pkg::fgr_state_t st_r;
  fgr_pkg::fgr_state_t st_nxt;
  logic [fgr_pkg::TMR_W-1:0] tmr_r;
  logic [fgr_pkg::TMR_W-1:0] tmr_nxt;
  logic pulse_n_r;

  localparam logic [fgr_pkg::TMR_W-1:0] DLY_LAST = fgr_pkg::TMR_W'(fgr_pkg::RST_DELAY_CYC - 1);
  localparam logic [fgr_pkg::TMR_W-1:0] PLS_LAST = fgr_pkg::TMR_W'(fgr_pkg::RST_PULSE_CYC - 1);

  wire trig = rst_bit_r;
  wire dly_done = (tmr_r == DLY_LAST);
  wire pls_done = (tmr_r == PLS_LAST);

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    case (st_r)
      fgr_pkg::FGR_IDLE: begin
        tmr_nxt = '0;
        if (trig) begin
          st_nxt = fgr_pkg::FGR_DELAY;
        end
      end
      fgr_pkg::FGR_DELAY: begin
        tmr_nxt = tmr_r + 1'b1;
        if (dly_done) begin
          st_nxt = fgr_pkg::FGR_PULSE;
          tmr_nxt = '0;
        end
      end
      fgr_pkg::FGR_PULSE: begin
        tmr_nxt = tmr_r + 1'b1;
        if (pls_done) begin
          st_nxt = fgr_pkg::FGR_DONE;
          tmr_nxt = '0;
        end
      end
      fgr_pkg::FGR_DONE: begin
        tmr_nxt = '0;
        if (!trig) begin
          st_nxt = fgr_pkg::FGR_IDLE;
        end
      end
      default: begin
        st_nxt = fgr_pkg::FGR_IDLE;
        tmr_nxt = '0;
      end
    endcase
  end

  wire pulse_n_nxt = (st_nxt != fgr_pkg::FGR_PULSE);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= fgr_pkg::FGR_IDLE;
      tmr_r <= '0;
      pulse_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      pulse_n_r <= pulse_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt latches
  logic kbd_prev_r;
  logic mouse_prev_r;
  logic kbd_lat_r;
  logic mouse_lat_r;

  wire kbd_raw = kbc_s2_r.kbd_irq;
  wire mouse_raw = kbc_s2_r.mouse_irq;
  wire kbd_lat_nxt = (kbd_raw && !kbd_prev_r) || (kbd_lat_r && kbd_raw);
  wire mouse_lat_nxt = (mouse_raw && !mouse_prev_r) || (mouse_lat_r && mouse_raw);

  wire kbd_sel = cfg_r[fgr_pkg::KBD_LATCH_SEL_BIT];
  wire mouse_sel = cfg_r[fgr_pkg::MOUSE_LATCH_SEL_BIT];
  wire kbd_irq_nxt = kbd_sel ? kbd_lat_nxt : (kbd_raw && kbd_lat_nxt);
  wire mouse_irq_nxt = mouse_sel ? mouse_lat_nxt : (mouse_raw && mouse_lat_nxt);

  ////////////////////////////////////////////////////////////////////////////
  // CPU-facing outputs
  wire kbc_rst_n = !kbc_s2_r.kbc_reset;
  wire rst_and = pulse_n_nxt && kbc_rst_n;
  wire rst_pol = cfg_r[fgr_pkg::RESET_POL_BIT];
  wire kbd_reset_nxt = rst_pol ? !rst_and : rst_and;
  wire mask_nxt = kbc_s2_r.kbc_gate_port_bit || a20_nxt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kbd_prev_r <= 1'b0;
      mouse_prev_r <= 1'b0;
      kbd_lat_r <= 1'b0;
      mouse_lat_r <= 1'b0;
      kbd_irq_out <= 1'b0;
      mouse_irq_out <= 1'b0;
      fast_reset_n <= 1'b1;
      fast_a20 <= 1'b0;
      kbd_reset_out_n <= 1'b1;
      a20_mask_n <= 1'b0;
    end else begin
      kbd_prev_r <= kbd_raw;
      mouse_prev_r <= mouse_raw;
      kbd_lat_r <= kbd_lat_nxt;
      mouse_lat_r <= mouse_lat_nxt;
      kbd_irq_out <= kbd_irq_nxt;
      mouse_irq_out <= mouse_irq_nxt;
      fast_reset_n <= pulse_n_nxt;
      fast_a20 <= a20_nxt;
      kbd_reset_out_n <= kbd_reset_nxt;
      a20_mask_n <= mask_nxt;
    end
  end

endmodule // fgr_fast_port

/* File: test/fgr_fast_port_monitor.sv */
// Purpose: Port-level assertions for the fast A20 / fast reset block
// Assumes: Config and bit 0 are tracked from host writes
// Notes: Bound onto the design after the module
`timescale 1ns/1ns
module fgr_fast_port_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire fgr_pkg::fgr_req_t req,
  input wire logic [7:0] rdata,
  input wire fgr_pkg::fgr_kbc_t kbc,
  input wire logic fast_reset_n,
  input wire logic fast_a20,
  input wire logic kbd_reset_out_n,
  input wire logic a20_mask_n,
  input wire logic kbd_irq_out,
  input wire logic mouse_irq_out
);
  logic en_r;
  logic pol_r;
  logic b0_r;
  logic [10:0] set_cnt_r;
  logic [9:0] lo_cnt_r;
  wire cfg_wr = req.wr && req.addr == fgr_pkg::CONFIG_ADDR;
  wire port_hit = req.addr == fgr_pkg::FAST_PORT_ADDR && en_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en_r <= 1'b0;
      pol_r <= 1'b0;
      b0_r <= 1'b0;
      set_cnt_r <= 11'h0;
      lo_cnt_r <= 10'h0;
    end else begin
      if (cfg_wr) en_r <= req.wdata[2];
      if (cfg_wr) pol_r <= req.wdata[5];
      if (req.wr && port_hit) b0_r <= req.wdata[0];
      set_cnt_r <= !b0_r ? 11'h0 : set_cnt_r + {10'h0, ~&set_cnt_r};
      lo_cnt_r <= fast_reset_n ? 10'h0 : lo_cnt_r + 10'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  rd_fixed_a: assert property (req.rd && port_hit |=>
    (rdata & 8'hfc) == 8'h24 && rdata[1:0] == {fast_a20, b0_r}) else $error("Port read pattern wrong");
  rd_off_a: assert property (req.rd && !port_hit && req.addr != fgr_pkg::CONFIG_ADDR
    |=> rdata == 8'h00) else $error("Refused read not zero");
  a20_wr_a: assert property (req.wr && port_hit |=> fast_a20 == $past(req.wdata[1]))
    else $error("Fast A20 not set by write");
  mask_or_a: assert property (fast_a20 |-> a20_mask_n) else $error("A20 mask low with fast A20");
  mask_low_a: assert property ((!kbc.kbc_gate_port_bit && !fast_a20) [*5] |-> !a20_mask_n)
    else $error("A20 mask high with both sources low");
  pulse_len_a: assert property ($rose(fast_reset_n) |-> lo_cnt_r == 10'h12c)
    else $error("Reset pulse length wrong");
  pulse_dly_a: assert property ($fell(fast_reset_n) |-> set_cnt_r >= 11'h2ba && set_cnt_r <= 11'h2c0)
    else $error("Reset pulse delay wrong or retriggered");
  kbd_rst_a: assert property (!fast_reset_n && $stable(pol_r) |-> kbd_reset_out_n == pol_r)
    else $error("Keyboard reset does not follow pulse");
  kbd_irq_a: assert property (kbc.kbd_irq [*5] |-> kbd_irq_out) else $error("Keyboard irq lost");
  mouse_irq_a: assert property (!kbc.mouse_irq [*5] |-> !mouse_irq_out) else $error("Mouse irq stuck");
endmodule // fgr_fast_port_monitor
bind fgr_fast_port fgr_fast_port_monitor i_fgr_fast_port_monitor (.ref_clk, .rst, .req, .rdata, .kbc,
  .fast_reset_n, .fast_a20, .kbd_reset_out_n, .a20_mask_n, .kbd_irq_out, .mouse_irq_out);

/* File: test/fgr_kbc_model.sv */
// Purpose: Keyboard controller side feeding the fast port block
// Assumes: Bench sets cmd off the clock edge
// Notes: Levels change only on ref_clk
`timescale 1ns/1ns
module fgr_kbc_model (
  input wire logic ref_clk,
  input wire logic [3:0] cmd,
  output fgr_pkg::fgr_kbc_t kbc
);
  initial kbc = '0;
  // Reset request, gate port bit and raw interrupts as levels
  always @(posedge ref_clk) kbc <= cmd;
endmodule // fgr_kbc_model

/* File: test/fgr_fast_port_tb.sv */
// Purpose: Self-checking bench for the fast A20 / fast reset block
// Assumes: 50 MHz clock, seeded xorshift stimulus
// Notes: Pulse timing measured in clock edges
`timescale 1ns/1ns
module fgr_fast_port_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  fgr_pkg::fgr_req_t req = '0;
  logic [3:0] kbc_cmd = 4'h0;
  fgr_pkg::fgr_kbc_t kbc;
  logic [7:0] rdata;
  logic fast_reset_n, fast_a20, kbd_reset_out_n, a20_mask_n, kbd_irq_out, mouse_irq_out;
  int n_mismatch = 0;
  int n_tests = 0;
  int cnt;
  logic [31:0] seed = 32'h5ab4;
  logic [7:0] rv;
  logic [7:0] d;
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  fgr_kbc_model i_fgr_kbc_model (.ref_clk(ref_clk), .cmd(kbc_cmd), .kbc(kbc));
  fgr_fast_port i_fgr_fast_port (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .kbc(kbc),
    .fast_reset_n(fast_reset_n), .fast_a20(fast_a20), .kbd_reset_out_n(kbd_reset_out_n),
    .a20_mask_n(a20_mask_n), .kbd_irq_out(kbd_irq_out), .mouse_irq_out(mouse_irq_out));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  function automatic logic [15:0] port_exp(input logic [7:0] w);
    return {8'h00, fgr_pkg::FAST_PORT_FIXED_VAL | (w & 8'h03)};
  endfunction
  task automatic close_out;
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk) req <= {a, v, 2'b10};
    @(posedge ref_clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) req <= {a, 8'h00, 2'b01};
    @(posedge ref_clk) req <= '0;
    #1 rv = rdata;
  endtask
  task automatic wfr(input logic lvl);
    cnt = 0;
    while (fast_reset_n !== lvl) begin
      wt(1);
      cnt++;
      if (cnt > 2000) begin
        n_mismatch++;
        close_out();
      end
    end
  endtask
  initial begin
    wt(20);
    rst <= 1'b0;
    wt(1);
    chk({fast_reset_n, fast_a20, a20_mask_n}, 16'h4);
    rd(fgr_pkg::FAST_PORT_ADDR);
    chk(rv, 16'h0);
    wr(fgr_pkg::FAST_PORT_ADDR, 8'h02);
    wt(2);
    chk(fast_a20, 16'h0);
    wr(fgr_pkg::CONFIG_ADDR, 8'h04);
    rd(fgr_pkg::FAST_PORT_ADDR);
    chk(rv, fgr_pkg::FAST_PORT_RESET);
    rd(8'h93);
    chk(rv, 16'h0);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = seed[7:0] & 8'hfe;
      kbc_cmd <= {1'b0, seed[9], 2'b00};
      wr(fgr_pkg::FAST_PORT_ADDR, d);
      rd(fgr_pkg::FAST_PORT_ADDR);
      chk(rv, port_exp(d));
      wt(4);
      chk({fast_a20, a20_mask_n}, {d[1], seed[9] | d[1]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(fgr_pkg::CONFIG_ADDR, 8'h04 | 8'(i << 3));
      kbc_cmd <= 4'h3;
      wt(6);
      chk({kbd_irq_out, mouse_irq_out}, 16'h3);
      kbc_cmd <= 4'h0;
      wt(6);
      chk({kbd_irq_out, mouse_irq_out}, 16'h0);
    end
    wr(fgr_pkg::CONFIG_ADDR, 8'h04);
    wr(fgr_pkg::FAST_PORT_ADDR, 8'h01);
    wfr(1'b0);
    chk(16'(cnt >= fgr_pkg::RST_DELAY_CYC), 16'h1);
    chk(kbd_reset_out_n, 16'h0);
    wfr(1'b1);
    chk(cnt[15:0], 16'(fgr_pkg::RST_PULSE_CYC));
    wt(1000);
    chk(fast_reset_n, 16'h1);
    rd(fgr_pkg::FAST_PORT_ADDR);
    chk(rv, 16'h25);
    wr(fgr_pkg::CONFIG_ADDR, 8'h24);
    rd(fgr_pkg::CONFIG_ADDR);
    chk(rv, 16'h24);
    wr(fgr_pkg::FAST_PORT_ADDR, 8'h00);
    wr(fgr_pkg::FAST_PORT_ADDR, 8'h01);
    wfr(1'b0);
    chk(kbd_reset_out_n, 16'h1);
    wfr(1'b1);
    wr(fgr_pkg::CONFIG_ADDR, 8'h04);
    kbc_cmd <= 4'h8;
    wt(6);
    chk(kbd_reset_out_n, 16'h0);
    kbc_cmd <= 4'h0;
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    wt(1);
    rd(fgr_pkg::CONFIG_ADDR);
    chk(rv, fgr_pkg::CONFIG_RESET);
    wr(fgr_pkg::CONFIG_ADDR, 8'h04);
    rd(fgr_pkg::FAST_PORT_ADDR);
    chk(rv, fgr_pkg::FAST_PORT_RESET);
    close_out();
  end
endmodule // fgr_fast_port_tb
